// *** ssrc_consts.vh ***
`ifndef SSRC_CONSTS_VH
`define SSRC_CONSTS_VH
// command codes and data numbers
`define SSRC_CMD_GROUP    8'h1f
`define SSRC_CMD_STATUS   8'h02
`define SSRC_DN_GROUP     8'h00
`define SSRC_DN_POS_MOTOR 8'h90
`define SSRC_DN_POS_CMD   8'h91
`define SSRC_DN_VERSION   8'h70
// group designation range
`define SSRC_GROUP_NONE   3'h0
`define SSRC_GROUP_MAX    3'h6
// reply lengths in characters
`define SSRC_LEN_GROUP    5'h01
`define SSRC_LEN_POS      5'h08
`define SSRC_LEN_VER      5'h10
// reply kinds
`define SSRC_KIND_GROUP   2'h0
`define SSRC_KIND_POS     2'h1
`define SSRC_KIND_VER     2'h2
`define SSRC_KIND_ERR     2'h3
// characters
`define SSRC_CHAR_SPACE   8'h20
`define SSRC_CHAR_ZERO    8'h30
`define SSRC_CHAR_ALPHA   8'h37
// motor revolution limit, as a bit index of the revolution count
`define SSRC_REV_LIMIT_BIT 13
`endif

// *** ssrc_hex_char.v ***
`timescale 1ns/1ps
`include "ssrc_consts.vh"
// one nibble to its upper-case ascii hex character, registered
module ssrc_hex_char (
	input  wire       ref_clk, // system clock
	input  wire       sys_rst, // async reset, active high
	input  wire [3:0] nibble,  // value to convert
	output reg  [7:0] char     // ascii character
);
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			char <= `SSRC_CHAR_ZERO;
		end else if (nibble > 4'h9) begin
			char <= {4'h0, nibble} + `SSRC_CHAR_ALPHA;
		end else begin
			char <= {4'h0, nibble} + `SSRC_CHAR_ZERO;
		end
	end
endmodule

// *** ssrc_read_cmd.v ***
`timescale 1ns/1ps
`include "ssrc_consts.vh"
//////////////////////////////////////////////////////////////////////////////
module ssrc_read_cmd #(
	parameter REV_BITS = 18 // encoder pulses per revolution, as log2
) (
	input  wire         ref_clk,     // system clock, 200 MHz
	input  wire         sys_rst,     // async reset, active high
	input  wire         req_valid,   // command present
	output wire         req_ready,   // idle, may take a command
	input  wire [7:0]   req_cmd,     // command code
	input  wire [7:0]   req_dnum,    // data number
	input  wire [2:0]   group_value, // stored group designation
	input  wire [31:0]  pos_motor,   // motor-side pulse position
	input  wire [31:0]  pos_command, // command-unit position
	input  wire [119:0] version_str, // 15 chars, first in top byte
	output reg          rep_valid,   // reply character valid
	input  wire         rep_ready,   // sink takes character
	output reg  [7:0]   rep_char,    // reply character
	output reg          rep_last,    // last character of reply
	output reg          rep_error,   // unknown command or invalid value
	output reg          rep_start    // first character of reply
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_SEND = 2'h2;

	reg  [1:0]   state;
	reg  [1:0]   kind;
	reg  [4:0]   idx;
	reg  [4:0]   len;
	reg  [31:0]  word;
	reg  [119:0] ver;
	reg  [1:0]   next_state;
	reg  [2:0]   grp;
	reg  [31:0]  nib_src;
	reg  [2:0]   nib_sel;
	reg  [3:0]   nib;
	wire [7:0]   hex_char;

	assign req_ready = (state == ST_IDLE);

	// bits above the revolution span mean the count wrapped
	function overflowed;
		input [31:0] p;
		reg   [31:0] a;
		begin
			a = p[31] ? (~p + 32'h1) : p;
			overflowed = |(a >> (REV_BITS + `SSRC_REV_LIMIT_BIT));
		end
	endfunction

	function [1:0] decode;
		input [7:0] c;
		input [7:0] d;
		begin
			decode = `SSRC_KIND_ERR;
			if (c == `SSRC_CMD_GROUP && d == `SSRC_DN_GROUP)
				decode = `SSRC_KIND_GROUP;
			else if (c == `SSRC_CMD_STATUS) begin
				if (d == `SSRC_DN_POS_MOTOR || d == `SSRC_DN_POS_CMD)
					decode = `SSRC_KIND_POS;
				else if (d == `SSRC_DN_VERSION)
					decode = `SSRC_KIND_VER;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// the converter is registered: feed it the nibble of the next char,
	// from the incoming word while idle, idx+1 while a char waits
	always @* begin
		nib_src = word;
		nib_sel = idx[2:0];
		if (state == ST_IDLE) begin
			if (req_dnum == `SSRC_DN_POS_MOTOR)
				nib_src = pos_motor;
			else
				nib_src = pos_command;
			nib_sel = 3'h0;
		end else if (state == ST_SEND) begin
			nib_sel = idx[2:0] + 3'h1;
		end
		case (nib_sel)
			3'h0: nib = nib_src[31:28];
			3'h1: nib = nib_src[27:24];
			3'h2: nib = nib_src[23:20];
			3'h3: nib = nib_src[19:16];
			3'h4: nib = nib_src[15:12];
			3'h5: nib = nib_src[11:8];
			3'h6: nib = nib_src[7:4];
			default: nib = nib_src[3:0];
		endcase
	end

	ssrc_hex_char u_hex (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.nibble  (nib),
		.char    (hex_char)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencing: idle, fetch one char, hold it until the sink takes it
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (req_valid)
				next_state = ST_CONV;
		end
		ST_CONV: begin
			next_state = ST_SEND;
		end
		ST_SEND: begin
			if (rep_ready && rep_last)
				next_state = ST_IDLE;
			else if (rep_ready)
				next_state = ST_CONV;
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			kind      <= `SSRC_KIND_GROUP;
			grp       <= `SSRC_GROUP_NONE;
			idx       <= 5'h0;
			len       <= 5'h0;
			word      <= 32'h0;
			ver       <= 120'h0;
			rep_valid <= 1'b0;
			rep_char  <= 8'h0;
			rep_last  <= 1'b0;
			rep_error <= 1'b0;
			rep_start <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (req_valid) begin
					kind      <= decode(req_cmd, req_dnum);
					idx       <= 5'h0;
					ver       <= version_str;
					grp       <= group_value;
					rep_error <= 1'b0;
					if (req_dnum == `SSRC_DN_POS_MOTOR) begin
						word      <= pos_motor;
						rep_error <= overflowed(pos_motor);
					end else begin
						word <= pos_command;
					end
					case (decode(req_cmd, req_dnum))
					`SSRC_KIND_GROUP: len <= `SSRC_LEN_GROUP;
					`SSRC_KIND_POS:   len <= `SSRC_LEN_POS;
					`SSRC_KIND_VER:   len <= `SSRC_LEN_VER;
					default:          len <= `SSRC_LEN_GROUP;
					endcase
					if (req_cmd != `SSRC_CMD_STATUS ||
						req_dnum != `SSRC_DN_POS_MOTOR)
						rep_error <= 1'b0;
				end
			end
			ST_CONV: begin
				// converter was fed a cycle ahead, its char is ready now
				rep_valid <= 1'b1;
				rep_start <= (idx == 5'h0);
				rep_last  <= (idx == len - 5'h1);
				case (kind)
				`SSRC_KIND_GROUP: begin
					// out-of-range values flagged, still sent as their digit
					rep_char  <= `SSRC_CHAR_ZERO + {5'h00, grp};
					if (grp > `SSRC_GROUP_MAX)
						rep_error <= 1'b1;
				end
				`SSRC_KIND_POS:
					rep_char <= hex_char;
				`SSRC_KIND_VER: begin
					if (idx == 5'h0)
						rep_char <= `SSRC_CHAR_SPACE;
					else begin
						rep_char <= ver[119:112];
						ver      <= {ver[111:0], 8'h0};
					end
				end
				default: begin
					rep_char  <= `SSRC_CHAR_SPACE;
					rep_error <= 1'b1;
				end
				endcase
			end
			ST_SEND: begin
				if (rep_ready) begin
					rep_valid <= 1'b0;
					rep_start <= 1'b0;
					rep_last  <= 1'b0;
					if (!rep_last) begin
						idx <= idx + 5'h1;
					end
				end
			end
			default: rep_valid <= 1'b0;
			endcase
		end
	end
endmodule

// *** ssrc_sink.sv ***
`timescale 1ns/1ps
module ssrc_sink (
	input  wire ref_clk,  // clock
	output reg  rep_ready // sink accepts char
);
	// random stalls so every char must hold while waiting
	initial rep_ready = 1'b0;
	always @(posedge ref_clk) begin
		rep_ready <= 1'($urandom_range(0, 1));
	end
endmodule

// *** ssrc_read_cmd_monitor.sv ***
`timescale 1ns/1ps
module ssrc_monitor (
	input wire        ref_clk,     // clock
	input wire        sys_rst,     // reset
	input wire        req_valid,   // request
	input wire        req_ready,   // idle
	input wire [7:0]  req_cmd,     // code
	input wire [7:0]  req_dnum,    // data number
	input wire [2:0]  group_value, // group
	input wire [31:0] pos_motor,   // position
	input wire        rep_valid,   // char valid
	input wire        rep_ready,   // sink ready
	input wire [7:0]  rep_char,    // char
	input wire        rep_last,    // last char
	input wire        rep_error,   // error
	input wire        rep_start    // first char
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire       tk = req_valid && req_ready;
	wire       hs = rep_valid && rep_ready;
	wire       gq = tk && req_cmd == 8'h1f && req_dnum == 8'h00;
	wire [3:0] nb = pos_motor[31:28];
	wire [7:0] hx = nb < 4'ha ? 8'h30 + nb : 8'h37 + nb;
	//////////////////////////////////////////////////////////////////////
	reply_start_a: assert property (
		tk |=> !rep_valid ##1 rep_valid && rep_start)
		else $error("reply not started two cycles after take");
	char_hold_a: assert property (
		rep_valid && !rep_ready |=> rep_valid && $stable(rep_char))
		else $error("reply char changed while stalled");
	group_char_a: assert property (
		gq && group_value <= 3'h6 |-> ##2
		rep_char == {5'h06, $past(group_value, 2)} && rep_last)
		else $error("group reply char wrong");
	group_err_a: assert property (gq && group_value == 3'h7 |-> ##2 rep_error)
		else $error("group out of range not flagged");
	version_lead_a: assert property (
		tk && req_cmd == 8'h02 && req_dnum == 8'h70 |-> ##2
		rep_char == 8'h20 && !rep_last)
		else $error("version reply lacks leading space");
	unknown_cmd_a: assert property (
		tk && req_cmd == 8'h55 |-> ##2
		rep_error && rep_last && rep_char == 8'h20)
		else $error("unknown command not refused");
	pos_msb_a: assert property (
		tk && req_cmd == 8'h02 && req_dnum == 8'h90 |-> ##2
		rep_char == $past(hx, 2) && !rep_last)
		else $error("position reply first char wrong");
	char_gap_a: assert property (hs && !rep_last |=> !rep_valid ##1 rep_valid)
		else $error("next char spacing wrong");
	idle_back_a: assert property (hs && rep_last |=> req_ready && !rep_valid)
		else $error("not idle after last char");
endmodule
bind ssrc_read_cmd ssrc_monitor u_mon (.ref_clk, .sys_rst, .req_valid,
	.req_ready, .req_cmd, .req_dnum, .group_value, .pos_motor, .rep_valid,
	.rep_ready, .rep_char, .rep_last, .rep_error, .rep_start);

// *** ssrc_read_cmd_tb.sv ***
`timescale 1ns/1ps
module ssrc_read_cmd_tb;
	logic         ref_clk = 0, sys_rst = 1, req_valid = 0, rep_ready;
	logic         req_ready, rep_valid, rep_last, rep_error, rep_start;
	logic [7:0]   req_cmd = 0, req_dnum = 0, rep_char;
	logic [2:0]   group_value = 0;
	logic [31:0]  pos_motor = 0, pos_command = 0, v;
	logic [119:0] version_str = 0, vs;
	logic [10:0]  q[$], e;
	int           num_errors = 0, comparisons = 0, cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	// small revolution width so the overflow boundary is reachable
	ssrc_read_cmd #(.REV_BITS(4)) u_dut (.ref_clk, .sys_rst, .req_valid,
		.req_ready, .req_cmd, .req_dnum, .group_value, .pos_motor,
		.pos_command, .version_str, .rep_valid, .rep_ready, .rep_char,
		.rep_last, .rep_error, .rep_start);
	ssrc_sink u_sink (.ref_clk, .rep_ready);
	//////////////////////////////////////////////////////////////////////
	function automatic [7:0] hx(input [3:0] n);
		hx = n < 4'ha ? 8'h30 + n : 8'h37 + n;
	endfunction
	task send(input [7:0] c, input [7:0] d);
		do @(negedge ref_clk); while (req_ready !== 1'b1);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_dnum <= d;
		@(posedge ref_clk);
		req_valid <= 1'b0;
	endtask
	task pos(input [7:0] d, input [31:0] x);
		logic r;
		r = d == 8'h90 && x[31:17] != 0;
		for (int i = 7; i >= 0; i--)
			q.push_back({1'b1, r, i == 0, hx(x[i*4 +: 4])});
		if (d == 8'h90) pos_motor <= x;
		else pos_command <= x;
		send(8'h02, d);
	endtask
	task conclude;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		v = $urandom(81807);
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int g = 0; g < 8; g++) begin
			q.push_back({g < 7, g > 6, 1'b1, 5'h06, g[2:0]});
			group_value <= g[2:0];
			send(8'h1f, 8'h00);
		end
		pos(8'h90, 32'h0001ffff);
		pos(8'h90, 32'h00020000);
		repeat (6) begin
			pos(8'h90, $urandom & 32'h0003ffff);
			pos(8'h91, $urandom);
		end
		q.push_back(11'h420);
		for (int i = 14; i >= 0; i--) begin
			vs[i*8 +: 8] = 8'($urandom);
			q.push_back({2'b10, i == 0, vs[i*8 +: 8]});
		end
		version_str <= vs;
		send(8'h02, 8'h70);
		q.push_back(11'h720);
		send(8'h55, 8'h00);
		q.push_back(11'h720);
		send(8'h1f, 8'h01);
		q.push_back(11'h720);
		send(8'h02, 8'h92);
		wait (q.size() == 0);
		@(posedge ref_clk);
		conclude;
	end
	// pops the oldest note on every accepted reply char
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			conclude;
		end else if (rep_valid === 1'b1 && rep_ready === 1'b1) begin
			e = q.pop_front();
			comparisons++;
			if (e[10] ? {rep_error, rep_last, rep_char} !== e[9:0]
				: {rep_error, rep_last} !== e[9:8]) begin
				num_errors++;
				$display("[ERR] %0t got %h exp %h", $time,
					{rep_error, rep_last, rep_char}, e[9:0]);
			end
		end
	end
endmodule
